// ### bench/lin_mode_ctrl_props.sv
/* Port checker of the mode and wake controller.
   Assumes one clock, synchronous reset and the bind at the foot. */
`default_nettype none
module lin_mode_ctrl_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // Pins
    input wire logic        supply_ok,
    input wire logic        mode_en,
    input wire logic        txd,
    input wire logic        rxd,
    input wire logic        bus_in,
    input wire logic        bus_oe_n,
    input wire logic        regulator_enable_output_oe_n,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // Sequences
    // ********************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sequence s_powered;
        supply_ok [*4];
    endsequence
    sequence s_normal;
        s_powered ##0 mode_en [*4];
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ********************
    // Properties
    // ********************
    AST_OFF_QUIET: assert property (regulator_enable_output_oe_n |-> bus_oe_n && rxd)
        else $error("comms active while regulator released");
    AST_TX_GATE: assert property (!bus_oe_n |-> !$past(txd) && !regulator_enable_output_oe_n)
        else $error("bus pulled without transmit low");
    AST_TX_DRIVE: assert property (s_normal ##0 !txd |=> !bus_oe_n)
        else $error("transmit low not driven in normal");
    AST_RX_PATH: assert property (s_normal ##0 !bus_in |=> !rxd)
        else $error("dominant bus not reported");
    AST_RX_LEVEL: assert property (!rxd |-> !$past(bus_in))
        else $error("receive low without dominant bus");
    AST_WAIT_OFF: assert property (!mode_en [*4] |-> bus_oe_n && rxd)
        else $error("comms on with enable low");
    AST_SLEEP_ENTRY: assert property (s_powered ##0 $fell(mode_en) |-> ##[1:3] regulator_enable_output_oe_n)
        else $error("enable low did not release regulator");
    AST_LOCAL_WAKE: assert property (s_powered ##0 regulator_enable_output_oe_n [*3] ##0 $rose(mode_en)
        |-> ##[1:3] !regulator_enable_output_oe_n)
        else $error("local wake missing");
    AST_UNDERVOLT: assert property (!supply_ok |-> ##[1:3] regulator_enable_output_oe_n)
        else $error("undervoltage kept regulator on");
    AST_POWER_UP: assert property ($rose(supply_ok) ##1 supply_ok [*3] |-> !regulator_enable_output_oe_n)
        else $error("power up did not enable regulator");
    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
        else $error("ack not a single pulse");
endmodule : lin_mode_ctrl_props

bind lin_mode_ctrl lin_mode_ctrl_props i_lin_mode_ctrl_props (
    .clk_sys(clk_sys), .srst(srst), .supply_ok(supply_ok), .mode_en(mode_en), .txd(txd), .rxd(rxd),
    .bus_in(bus_in), .bus_oe_n(bus_oe_n), .regulator_enable_output_oe_n(regulator_enable_output_oe_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ### bench/lin_mode_ctrl_tb_top.sv
/* Self-checking bench of the mode and wake controller.
   Assumes the node model and the bound checker beside it. */
`default_nettype none
module lin_mode_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lin_mode_pkg::*;
    logic        clk_sys = 1'b0, srst = 1'b1, supply_ok = 1'b1, wake_sw = 1'b0;
    logic        en_req = 1'b0, txd_req = 1'b1, dom_req = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic        ack, rxd, bus_in, bus_out, bus_oe_n, mode_en, txd, reg_out, reg_oe_n, reg_pin;
    int          fail_count = 0, total_checks = 0, n;
    always #5 clk_sys = ~clk_sys;
    lin_mode_ctrl #(.SW_FILT_CYC(8), .BUS_FILT_DEF(16'h0004)) i_lin_mode_ctrl (
        .clk_sys(clk_sys), .srst(srst), .supply_ok(supply_ok), .mode_en(mode_en), .txd(txd), .rxd(rxd),
        .wake_sw(wake_sw), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
        .regulator_enable_output_in(reg_pin), .regulator_enable_output_out(reg_out),
        .regulator_enable_output_oe_n(reg_oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
    lin_node_model i_lin_node_model (
        .clk_sys(clk_sys), .en_req(en_req), .txd_req(txd_req), .dom_req(dom_req), .mode_en(mode_en),
        .txd(txd), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .bus_in(bus_in), .reg_out(reg_out),
        .reg_oe_n(reg_oe_n), .reg_pin(reg_pin));
    // ********************
    // Shared tasks
    // ********************
    task automatic final_report();
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cycles(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cycles
    // Bounded wait on ack, or on the regulator output enable; a lost answer ends the run
    task automatic wait_for(input logic on_reg, input logic lvl);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((on_reg ? reg_oe_n : ack) !== lvl && n < 60);
        if ((on_reg ? reg_oe_n : ack) !== lvl) begin
            fail_count++;
            final_report();
        end
    endtask : wait_for
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wait_for(1'b0, 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic mode_is(input logic [1:0] m);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("mode", rdat & 32'h3, {30'h0, m});
    endtask : mode_is
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        wb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", rdat, 32'h3);
        wb(1'b0, OFS_BUS_FILT, 32'h0);
        chk("bus_filt", rdat, 32'h4);
        wb(1'b1, 4'hc, 32'h0);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", rdat, 32'h0);
        wb(1'b1, OFS_BUS_FILT, 32'h5);
        wb(1'b0, OFS_BUS_FILT, 32'h0);
        chk("bus_filt_wr", rdat, 32'h5);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rdat & 32'h103, 32'h101);
    endtask : t_regs
    task automatic t_wait_gate();
        txd_req <= 1'b0;
        dom_req <= 1'b1;
        cycles(6);
        chk("wait_tx", bus_oe_n, 1'b1);
        chk("wait_rx", rxd, 1'b1);
        chk("wait_reg", reg_pin, 1'b1);
        txd_req <= 1'b1;
        dom_req <= 1'b0;
    endtask : t_wait_gate
    task automatic t_normal();
        en_req <= 1'b1;
        cycles(4);
        txd_req <= 1'b0;
        // Pin stage, bus drive and receive register each take one edge
        cycles(4);
        chk("tx_dom", bus_in, 1'b0);
        chk("rx_dom", rxd, 1'b0);
        txd_req <= 1'b1;
        cycles(4);
        chk("rx_rec", rxd, 1'b1);
        mode_is(MODE_NORMAL);
    endtask : t_normal
    task automatic t_sleep();
        en_req <= 1'b0;
        txd_req <= 1'b0;
        cycles(5);
        chk("sleep_reg", reg_pin, 1'b0);
        chk("sleep_tx", bus_oe_n, 1'b1);
        txd_req <= 1'b1;
        mode_is(MODE_SLEEP);
    endtask : t_sleep
    task automatic t_bus_wake();
        dom_req <= 1'b1;
        cycles(4);
        dom_req <= 1'b0;
        cycles(8);
        mode_is(MODE_SLEEP);
        dom_req <= 1'b1;
        wait_for(1'b1, 1'b0);
        chk("filt_len", 32'(n >= 5), 32'h1);
        dom_req <= 1'b0;
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("bus_wake", rdat & 32'h13, 32'h11);
        wb(1'b1, OFS_STATUS, 32'h70);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("w1c", rdat & 32'h70, 32'h0);
    endtask : t_bus_wake
    task automatic t_local();
        t_normal();
        t_sleep();
        en_req <= 1'b1;
        cycles(4);
        mode_is(MODE_NORMAL);
    endtask : t_local
    task automatic t_switch(input logic lvl);
        // Sticky flags from earlier wakes would mask a missing switch wake
        wb(1'b1, OFS_STATUS, 32'h70);
        wake_sw <= lvl;
        en_req <= 1'b1;
        cycles(16);
        t_sleep();
        chk("sw_ref", rdat[ST_SW_REF], lvl);
        wake_sw <= !lvl;
        cycles(4);
        wake_sw <= lvl;
        cycles(12);
        mode_is(MODE_SLEEP);
        wake_sw <= !lvl;
        wait_for(1'b1, 1'b0);
        chk("sw_filt", 32'(n >= 8), 32'h1);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("sw_wake", rdat & 32'h23, 32'h21);
    endtask : t_switch
    task automatic t_supply();
        supply_ok <= 1'b0;
        cycles(4);
        chk("uv_reg", reg_pin, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("uv_mode", rdat & 32'h103, 32'h0);
        supply_ok <= 1'b1;
        cycles(4);
        chk("pu_reg", reg_pin, 1'b1);
        mode_is(MODE_WAIT);
    endtask : t_supply
    initial begin
        cycles(16);
        srst <= 1'b0;
        cycles(4);
        t_regs();
        t_wait_gate();
        t_normal();
        t_sleep();
        t_bus_wake();
        t_local();
        t_switch(1'b0);
        t_switch(1'b1);
        t_supply();
        final_report();
    end
endmodule : lin_mode_ctrl_tb_top
`default_nettype wire

// ### bench/lin_node_model.sv
/* Host controller pins, bus wire and regulator pin of the node.
   Assumes requests from the bench change right after a clock edge. */
`default_nettype none
module lin_node_model (
    // Clock and bench requests
    input  wire logic clk_sys,
    input  wire logic en_req,
    input  wire logic txd_req,
    input  wire logic dom_req,
    // Host pins
    output var logic  mode_en,
    output var logic  txd,
    // Bus wire
    input  wire logic bus_out,
    input  wire logic bus_oe_n,
    output logic      bus_in,
    // Regulator pin
    input  wire logic reg_out,
    input  wire logic reg_oe_n,
    output logic      reg_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Host keeps transmitting as asked, even with comms off, to expose gating
    always @(posedge clk_sys) begin
        mode_en <= en_req;
        txd <= txd_req;
    end
    // Other node pulls dominant for wake frames; pull-up otherwise
    assign bus_in = !((!bus_oe_n && !bus_out) || dom_req);
    // Regulator inhibit input reads low when released
    assign reg_pin = !reg_oe_n ? reg_out : 1'b0;
endmodule : lin_node_model
`default_nettype wire

// ### hdl/filt_if.sv
/*
 * Carrier between the mode controller and its level filters:
 * raw level, acceptance count and filtered level.
 * Assumes both ends run on the same system clock.
 */
`default_nettype none

interface filt_if #(
    parameter int CW = 16
);
    logic          raw;
    logic [CW-1:0] limit;
    logic          level;

    modport filt (input raw, input limit, output level);
    modport user (output raw, output limit, input level);
endinterface : filt_if

`default_nettype wire

// ### hdl/level_filter.sv
/*
 * Level filter: the output follows the raw input only after the
 * input has differed from it for limit consecutive cycles.
 * Assumes raw is already synchronous to clk_sys.
 */
`default_nettype none

module level_filter #(
    parameter int   CW   = 16,
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Filter carrier
    filt_if.filt     f
);

    logic [CW-1:0] cnt_q;
    logic          level_q;

    // ************************************************************
    // Persistence counter
    // ************************************************************
    // A limit of zero behaves as one: no path passes unfiltered
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q   <= '0;
            level_q <= INIT;
        end else if (f.raw == level_q) begin
            cnt_q <= '0;
        end else if (cnt_q + 1'b1 >= f.limit) begin
            cnt_q   <= '0;
            level_q <= f.raw;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign f.level = level_q;

endmodule : level_filter

`default_nettype wire

// ### hdl/lin_mode_ctrl.sv
/*
 * Operating mode and wake controller of a single-wire bus
 * transceiver, with a classic Wishbone register slave.
 * Assumes all pins are synchronous to clk_sys and supply_ok comes
 * from an external undervoltage comparator.
 */
// Decided for this implementation: the address map and the Wishbone slave port.
// Behaviour
// - Filtered bus falling edge in sleep: regulator on, go to wait-for-normal.
// - Wait-for-normal holds, communication off, until mode enable is high.
// - Mode enable high during sleep goes straight to normal.
// - Normal mode: transmit and receive paths both active.
// - Sleep: transmit off, low power, wakes from bus, enable or switch.
// - Supply rising from zero enters wait-for-normal with regulator on.
// - Wake switch activation in sleep: wait-for-normal, regulator on.
// - Enable low in normal enters sleep; regulator released, comms off.
// - Undervoltage forces unpowered; supply return enters wait-for-normal.
// - Wait-for-normal: regulator on, transmit and receive off.
// - Bus receive level filtered so short spikes never wake.
// - Switch level stored on sleep entry; opposite level is the wake.
// - Wake switch filtered about fifty microseconds before acceptance.
// - Enabled: transmit low drives bus dominant, high releases it.
// - Receive output high for recessive bus, low for dominant.
`default_nettype none

module lin_mode_ctrl
    import lin_mode_pkg::*;
#(
    parameter int          SW_FILT_CYC  = lin_mode_pkg::WAKE_SW_FILT_CYC,
    parameter logic [15:0] BUS_FILT_DEF = 16'(lin_mode_pkg::BUS_FILT_CYC)
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Supply monitor
    input  wire logic        supply_ok,
    // Host pins
    input  wire logic        mode_en,
    input  wire logic        txd,
    output logic             rxd,
    // Wake switch
    input  wire logic        wake_sw,
    // Bus line, open drain
    input  wire logic        bus_in,
    output logic             bus_out,
    output logic             bus_oe_n,
    // Regulator enable output, high side or released
    input  wire logic        regulator_enable_output_in,
    output logic             regulator_enable_output_out,
    output logic             regulator_enable_output_oe_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    import lin_mode_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic [1:0] mode_code(input mode_state_t s);
        logic [1:0] c;
        c = MODE_UNPOWERED;
        unique case (s)
            ST_UNPOWERED:   c = MODE_UNPOWERED;
            ST_WAIT_NORMAL: c = MODE_WAIT;
            ST_NORMAL:      c = MODE_NORMAL;
            ST_SLEEP:       c = MODE_SLEEP;
        endcase
        return c;
    endfunction : mode_code

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [15:0] SW_LIMIT = 16'(SW_FILT_CYC);

    mode_state_t state_q;
    mode_state_t state_d;

    logic [1:0]  ctrl_q;
    logic [15:0] bus_filt_q;
    logic        wk_bus_q;
    logic        wk_sw_q;
    logic        wk_local_q;
    logic        sw_ref_q;
    logic        bus_filt_prev_q;
    logic        comm_on;
    logic        reg_on;
    logic        bus_wake;
    logic        sw_wake;
    logic        local_wake;
    logic        go_sleep;
    logic        bus_drive_q;
    logic        rxd_q;
    logic        reg_drive_q;
    logic        wb_req;
    logic        wb_wr;
    logic        wr_ctrl;
    logic        wr_status;
    logic        wr_filt;
    logic [31:0] rd_data;
    logic [31:0] dat_q;
    logic        ack_q;
    logic [31:0] filt_merged;

    filt_if #(.CW(FILT_W)) bus_f ();
    filt_if #(.CW(FILT_W)) sw_f ();

    // ************************************************************
    // Input filters
    // ************************************************************
    // Bus idles recessive, so the filter starts high
    assign bus_f.raw   = bus_in;
    assign bus_f.limit = bus_filt_q;

    level_filter #(
        .CW   (FILT_W),
        .INIT (1'b1)
    ) u_bus_filt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .f       (bus_f)
    );

    assign sw_f.raw   = wake_sw;
    assign sw_f.limit = SW_LIMIT;

    level_filter #(
        .CW   (FILT_W),
        .INIT (1'b0)
    ) u_sw_filt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .f       (sw_f)
    );

    // ************************************************************
    // Wake detection
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_filt_prev_q <= 1'b1;
        end else begin
            bus_filt_prev_q <= bus_f.level;
        end
    end

    // Reference is taken from the filtered level, so a bouncing
    // switch at sleep entry cannot itself wake the device
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sw_ref_q <= 1'b0;
        end else if (go_sleep) begin
            sw_ref_q <= sw_f.level;
        end
    end

    // Recessive to dominant edge of the filtered bus
    assign bus_wake = (state_q == ST_SLEEP)
                    && ctrl_q[CTRL_BUS_WAKE_EN]
                    && bus_filt_prev_q
                    && !bus_f.level;

    assign sw_wake = (state_q == ST_SLEEP)
                   && ctrl_q[CTRL_SW_WAKE_EN]
                   && (sw_f.level != sw_ref_q);

    assign local_wake = (state_q == ST_SLEEP) && mode_en;

    assign go_sleep = (state_q == ST_NORMAL) && !mode_en
                    && supply_ok;

    // ************************************************************
    // Mode state machine
    // ************************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_UNPOWERED: begin
                if (supply_ok) begin
                    state_d = ST_WAIT_NORMAL;
                end
            end
            ST_WAIT_NORMAL: begin
                if (mode_en) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (!mode_en) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Host command wins, it needs no regulator start-up
                if (local_wake) begin
                    state_d = ST_NORMAL;
                end else if (bus_wake) begin
                    state_d = ST_WAIT_NORMAL;
                end else if (sw_wake) begin
                    state_d = ST_WAIT_NORMAL;
                end
            end
        endcase
        if (!supply_ok) begin
            state_d = ST_UNPOWERED;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_UNPOWERED;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    assign comm_on = (state_q == ST_NORMAL);

    assign reg_on = (state_q == ST_WAIT_NORMAL)
                 || (state_q == ST_NORMAL);

    // Dominant only from txd low with communication on
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_drive_q <= 1'b0;
        end else begin
            bus_drive_q <= comm_on && !txd;
        end
    end

    // Receive path idles high while communication is off
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= comm_on ? bus_in : 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_drive_q <= 1'b0;
        end else begin
            reg_drive_q <= reg_on;
        end
    end

    assign bus_out  = 1'b0;
    assign bus_oe_n = !bus_drive_q;
    assign rxd      = rxd_q;

    // Released rather than driven low in sleep and unpowered
    assign regulator_enable_output_out  = 1'b1;
    assign regulator_enable_output_oe_n = !reg_drive_q;

    // ************************************************************
    // Wake source flags
    // ************************************************************
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wk_bus_q   <= 1'b0;
            wk_sw_q    <= 1'b0;
            wk_local_q <= 1'b0;
        end else begin
            wk_bus_q <= (state_d == ST_WAIT_NORMAL && bus_wake)
                     || (wk_bus_q && !(wr_status
                     && wb_sel_i[0] && wb_dat_i[ST_WK_BUS]));
            wk_sw_q <= (state_d == ST_WAIT_NORMAL && sw_wake
                     && !bus_wake)
                     || (wk_sw_q && !(wr_status
                     && wb_sel_i[0] && wb_dat_i[ST_WK_SW]));
            wk_local_q <= (state_d == ST_NORMAL && local_wake)
                       || (wk_local_q && !(wr_status
                       && wb_sel_i[0] && wb_dat_i[ST_WK_LOCAL]));
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // One wait state: ack one cycle after the request, then low
    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr     = wb_req && wb_we_i;
    assign wr_ctrl   = wb_wr && (wb_adr_i == OFS_CTRL);
    assign wr_status = wb_wr && (wb_adr_i == OFS_STATUS);
    assign wr_filt   = wb_wr && (wb_adr_i == OFS_BUS_FILT);

    assign filt_merged = merge_bytes({16'h0000, bus_filt_q},
                                     wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_filt_q <= BUS_FILT_DEF;
        end else if (wr_filt) begin
            bus_filt_q <= filt_merged[15:0];
        end
    end

    // Unmapped offsets read zero and ignore writes
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_CTRL: begin
                rd_data[1:0] = ctrl_q;
            end
            OFS_STATUS: begin
                rd_data[ST_MODE_LSB +: 2] = mode_code(state_q);
                rd_data[ST_WK_BUS]        = wk_bus_q;
                rd_data[ST_WK_SW]         = wk_sw_q;
                rd_data[ST_WK_LOCAL]      = wk_local_q;
                rd_data[ST_SUPPLY_OK]     = supply_ok;
                rd_data[ST_SW_REF]        = sw_ref_q;
            end
            OFS_BUS_FILT: begin
                rd_data[15:0] = bus_filt_q;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dat_q <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            dat_q <= rd_data;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule : lin_mode_ctrl

`default_nettype wire

// ### hdl/lin_mode_pkg.sv
/*
 * Shared constants of the transceiver mode and wake controller:
 * register map, field positions, reset values and filter timing.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none

package lin_mode_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_MHZ          = 100;
    localparam int WAKE_SW_FILT_US  = 50;
    // Nominal time, so plain product; always above one cycle
    localparam int WAKE_SW_FILT_CYC = WAKE_SW_FILT_US * CLK_MHZ;
    localparam int BUS_FILT_CYC     = 3000;
    localparam int FILT_W           = 16;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_STATUS   = 4'h4;
    localparam logic [3:0] OFS_BUS_FILT = 4'h8;

    // Control fields
    localparam int CTRL_BUS_WAKE_EN = 0;
    localparam int CTRL_SW_WAKE_EN  = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;

    // Status fields
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_WK_BUS    = 4;
    localparam int ST_WK_SW     = 5;
    localparam int ST_WK_LOCAL  = 6;
    localparam int ST_SUPPLY_OK = 8;
    localparam int ST_SW_REF    = 9;

    // Mode codes shown in status
    localparam logic [1:0] MODE_UNPOWERED = 2'h0;
    localparam logic [1:0] MODE_WAIT      = 2'h1;
    localparam logic [1:0] MODE_NORMAL    = 2'h2;
    localparam logic [1:0] MODE_SLEEP     = 2'h3;

    typedef enum logic [1:0] {
        ST_UNPOWERED,
        ST_WAIT_NORMAL,
        ST_NORMAL,
        ST_SLEEP
    } mode_state_t;

endpackage : lin_mode_pkg

`default_nettype wire
